// File: verilog/msc_ctrl.v
`timescale 1ns/100ps
`include "msc_regs.vh"
module msc_ctrl (
  input wire CLK,
  input wire RESET_N,
  input wire MODULE_SELECT_PIN_N,
  input wire MODULE_SELECT_DRIVEN,
  input wire MODULE_RESET_N,
  input wire LOW_POWER_SELECT,
  input wire FAULT_EVENT,
  input wire STATUS_READ_DONE,
  output reg SERIAL_ENABLE,
  output reg USER_SETTINGS_RESET,
  output reg INIT_PENDING,
  output reg LOW_POWER_ACTIVE,
  output reg PRESENCE_N_OUT,
  output reg PRESENCE_N_OE,
  output reg ATTENTION_N_OUT,
  output reg ATTENTION_N_OE,
  output reg FAULT_FLAG
);
  localparam ST_POWERUP = 2'b00;
  localparam ST_HELD = 2'b01;
  localparam ST_INIT = 2'b10;
  localparam ST_RUN = 2'b11;
  // completion interval count, cut to the timer width on purpose
  localparam [31:0] INIT_LOAD = `MSC_INIT_CYC;

  wire select_raw;
  wire [`MSC_SYNC_W-1:0] sync_in;
  wire [`MSC_SYNC_W-1:0] sync_out;
  wire module_select_n;
  wire module_reset_n;
  wire low_power_select;
  wire init_done;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`MSC_CNT_W-1:0] low_cnt_q;
  reg timer_start;
  reg reset_seen_q;
  reg done_irq_q;
  reg fault_q;

  assign select_raw = MODULE_SELECT_DRIVEN ? MODULE_SELECT_PIN_N : 1'b1;
  assign sync_in[`MSC_IDX_SEL] = select_raw;
  assign sync_in[`MSC_IDX_RST] = MODULE_RESET_N;
  assign sync_in[`MSC_IDX_LP] = LOW_POWER_SELECT;

  msc_sync u_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .async_in(sync_in),
    .sync_out(sync_out)
  );
  assign module_select_n = sync_out[`MSC_IDX_SEL];
  assign module_reset_n = sync_out[`MSC_IDX_RST];
  assign low_power_select = sync_out[`MSC_IDX_LP];

  msc_timer u_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(timer_start),
    .load(INIT_LOAD[`MSC_CNT_W-1:0]),
    .done(init_done)
  );

  always @(posedge CLK) begin
    if (!RESET_N) begin
      low_cnt_q <= {`MSC_CNT_W{1'b0}};
      reset_seen_q <= 1'b0;
    end else if (!module_reset_n) begin
      if (low_cnt_q != `MSC_RESET_MIN_CYC)
        low_cnt_q <= low_cnt_q + 16'h0001;
      else
        reset_seen_q <= 1'b1;
    end else begin
      low_cnt_q <= {`MSC_CNT_W{1'b0}};
      reset_seen_q <= 1'b0;
    end
  end

  always @* begin
    state_d = state_q;
    timer_start = 1'b0;
    case (state_q)
      ST_POWERUP: begin
        timer_start = 1'b1;
        state_d = ST_INIT;
      end
      ST_HELD: begin
        if (module_reset_n) begin
          timer_start = 1'b1;
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (reset_seen_q)
          state_d = ST_HELD;
        else if (init_done)
          state_d = ST_RUN;
      end
      ST_RUN: begin
        if (reset_seen_q)
          state_d = ST_HELD;
      end
      default: state_d = ST_POWERUP;
    endcase
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      state_q <= ST_POWERUP;
      SERIAL_ENABLE <= 1'b0;
      USER_SETTINGS_RESET <= 1'b1;
      INIT_PENDING <= 1'b1;
      LOW_POWER_ACTIVE <= 1'b1;
      PRESENCE_N_OUT <= 1'b0;
      PRESENCE_N_OE <= 1'b1;
      ATTENTION_N_OUT <= 1'b0;
      ATTENTION_N_OE <= 1'b0;
      FAULT_FLAG <= 1'b0;
      done_irq_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      state_q <= state_d;
      SERIAL_ENABLE <= !module_select_n && (state_q != ST_HELD);
      USER_SETTINGS_RESET <= (state_d == ST_HELD) || (state_d == ST_POWERUP);
      INIT_PENDING <= (state_d != ST_RUN);
      LOW_POWER_ACTIVE <= low_power_select;
      PRESENCE_N_OUT <= 1'b0;
      PRESENCE_N_OE <= 1'b1;
      // completion event, set wins over clear
      if (state_q == ST_INIT && state_d == ST_RUN)
        done_irq_q <= 1'b1;
      else if (STATUS_READ_DONE || state_d != ST_RUN)
        done_irq_q <= 1'b0;
      // fault latch, set wins over clear
      if (FAULT_EVENT && state_q == ST_RUN)
        fault_q <= 1'b1;
      else if (STATUS_READ_DONE || state_d != ST_RUN)
        fault_q <= 1'b0;
      FAULT_FLAG <= (FAULT_EVENT && state_q == ST_RUN) ||
        (fault_q && !STATUS_READ_DONE && state_d == ST_RUN);
      ATTENTION_N_OUT <= 1'b0;
      ATTENTION_N_OE <= (state_q == ST_INIT && state_d == ST_RUN) ||
        (FAULT_EVENT && state_q == ST_RUN) ||
        ((done_irq_q || fault_q) && !STATUS_READ_DONE && state_d == ST_RUN);
    end
  end
endmodule // msc_ctrl

// File: verilog/msc_regs.vh
`ifndef MSC_REGS_VH
`define MSC_REGS_VH
// clock period in ns
`define MSC_CLK_PERIOD_NS 4
// minimum reset pulse seen as a real reset, in ns
`define MSC_RESET_MIN_NS 2000
`define MSC_RESET_MIN_CYC ((`MSC_RESET_MIN_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
// reset completion interval, in ns
`define MSC_INIT_NS 10000
`define MSC_INIT_CYC (`MSC_INIT_NS / `MSC_CLK_PERIOD_NS)
`define MSC_CNT_W 16
`define MSC_SYNC_W 3
// positions in the synchronised input vector
`define MSC_IDX_SEL 0
`define MSC_IDX_RST 1
`define MSC_IDX_LP 2
`endif

// File: verilog/msc_sync.v
`timescale 1ns/100ps
`include "msc_regs.vh"
module msc_sync (
  input wire clk,
  input wire reset_n,
  input wire [`MSC_SYNC_W-1:0] async_in,
  output wire [`MSC_SYNC_W-1:0] sync_out
);
  reg [`MSC_SYNC_W-1:0] meta_q;
  reg [`MSC_SYNC_W-1:0] sync_q;
  genvar i;
  generate
    for (i = 0; i < `MSC_SYNC_W; i = i + 1) begin : g_bit
      // inputs idle high (pull-up level) under reset
      always @(posedge clk) begin
        if (!reset_n) begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign sync_out = sync_q;
endmodule // msc_sync

// File: verilog/msc_timer.v
`timescale 1ns/100ps
`include "msc_regs.vh"
module msc_timer (
  input wire clk,
  input wire reset_n,
  input wire start,
  input wire [`MSC_CNT_W-1:0] load,
  output wire done
);
  reg [`MSC_CNT_W-1:0] cnt_q;
  reg done_q;
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= {`MSC_CNT_W{1'b0}};
      done_q <= 1'b0;
    end else if (start) begin
      cnt_q <= load;
      done_q <= 1'b0;
    end else if (cnt_q != {`MSC_CNT_W{1'b0}}) begin
      cnt_q <= cnt_q - 16'h0001;
      done_q <= (cnt_q == 16'h0001);
    end else begin
      done_q <= 1'b0;
    end
  end
  assign done = done_q;
endmodule // msc_timer

// File: dv/msc_ctrl_properties.sv
`timescale 1ns/100ps
module msc_ctrl_properties (
  input wire CLK,
  input wire RESET_N,
  input wire MODULE_SELECT_PIN_N,
  input wire MODULE_SELECT_DRIVEN,
  input wire LOW_POWER_SELECT,
  input wire FAULT_EVENT,
  input wire STATUS_READ_DONE,
  input wire SERIAL_ENABLE,
  input wire USER_SETTINGS_RESET,
  input wire INIT_PENDING,
  input wire LOW_POWER_ACTIVE,
  input wire PRESENCE_N_OUT,
  input wire PRESENCE_N_OE,
  input wire ATTENTION_N_OUT,
  input wire ATTENTION_N_OE
);
  wire desel = MODULE_SELECT_PIN_N | ~MODULE_SELECT_DRIVEN;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  property p_sink; ATTENTION_N_OE |-> !ATTENTION_N_OUT; endproperty
  a_sink: assert property (p_sink) else $error("attention driven high");
  property p_prs; PRESENCE_N_OE && !PRESENCE_N_OUT; endproperty
  a_prs: assert property (p_prs) else $error("presence not low");
  property p_done; $fell(INIT_PENDING) |-> ATTENTION_N_OE; endproperty
  a_done: assert property (p_done) else $error("no completion flag");
  property p_desel; desel[*4] |=> !SERIAL_ENABLE; endproperty
  a_desel: assert property (p_desel) else $error("serial on deselected");
  property p_sel; (!desel && !INIT_PENDING)[*4] |=> SERIAL_ENABLE; endproperty
  a_sel: assert property (p_sel) else $error("serial off selected");
  property p_lp; LOW_POWER_SELECT[*4] |=> LOW_POWER_ACTIVE; endproperty
  a_lp: assert property (p_lp) else $error("low power missing");
  property p_clr; STATUS_READ_DONE && !FAULT_EVENT && !INIT_PENDING |=> !ATTENTION_N_OE;
  endproperty
  a_clr: assert property (p_clr) else $error("attention not cleared");
  property p_flt; FAULT_EVENT && !INIT_PENDING |-> ##[1:3] ATTENTION_N_OE; endproperty
  a_flt: assert property (p_flt) else $error("fault not reported");
  property p_rst; USER_SETTINGS_RESET |-> INIT_PENDING; endproperty
  a_rst: assert property (p_rst) else $error("reset without pending");
endmodule // msc_ctrl_properties
bind msc_ctrl msc_ctrl_properties u_msc_ctrl_properties (.*);

// File: dv/msc_host.sv
`timescale 1ns/100ps
module msc_host (
  input wire att_oe,
  input wire att_out,
  input wire prs_oe,
  input wire prs_out,
  output wire att_line_n,
  output wire prs_line_n
);
  assign att_line_n = att_oe ? att_out : 1'h1;
  assign prs_line_n = prs_oe ? prs_out : 1'h1;
endmodule // msc_host

// File: dv/module_sideband_control_bench.sv
`timescale 1ns/100ps
`include "msc_regs.vh"
module module_sideband_control_bench;
  reg clk = 0, rst_n = 0, sel_n = 1, drv = 1, mr_n = 1, lp = 0, flt = 0, rd = 0;
  reg [31:0] rnd = 32'h243CB13D;
  wire ser, usr, ip, lpa, po, poe, ao, aoe, flag, att, prs;
  integer mismatches = 0, total_checks = 0, n;
  initial forever #2 clk = ~clk;
  msc_ctrl u_msc_ctrl (.CLK(clk), .RESET_N(rst_n), .MODULE_SELECT_PIN_N(sel_n),
    .MODULE_SELECT_DRIVEN(drv), .MODULE_RESET_N(mr_n), .LOW_POWER_SELECT(lp),
    .FAULT_EVENT(flt), .STATUS_READ_DONE(rd), .SERIAL_ENABLE(ser),
    .USER_SETTINGS_RESET(usr), .INIT_PENDING(ip), .LOW_POWER_ACTIVE(lpa),
    .PRESENCE_N_OUT(po), .PRESENCE_N_OE(poe), .ATTENTION_N_OUT(ao),
    .ATTENTION_N_OE(aoe), .FAULT_FLAG(flag));
  msc_host u_msc_host (.att_oe(aoe), .att_out(ao), .prs_oe(poe), .prs_out(po),
    .att_line_n(att), .prs_line_n(prs));
  function [31:0] xs(input [31:0] v);
    begin
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction
  task check(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s exp %0d seen %0d", nm, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task cyc(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  // bounded wait for completion, then the interval is judged
  // host ignores status bits until completion
  task wait_done;
    begin
      n = 0;
      while (ip !== 1'h0 && n < 3000) begin
        cyc(1);
        n = n + 1;
      end
      if (n >= 3000) mismatches = mismatches + 1;
      if (n >= 3000) close_out;
      check("interval", n >= `MSC_INIT_CYC && n <= `MSC_INIT_CYC + 8, 1);
      check("att_line", att, 0);
      $display("reset completion test done");
    end
  endtask
  // host pulses rd (STATUS_READ_DONE) for one cycle after attention, then checks the line released
  task pulse_rd;
    begin
      @(posedge clk);
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      cyc(2);
      check("att_clr", att, 1);
    end
  endtask
  initial begin
    cyc(4);
    rst_n <= 1;
    wait_done;
    check("presence", prs, 0);
    pulse_rd;
    @(posedge clk);
    flt <= 1;
    @(posedge clk);
    flt <= 0;
    cyc(3);
    check("fault", {att, flag}, 1);
    pulse_rd;
    repeat (40) begin
      rnd = xs(rnd);
      @(posedge clk);
      sel_n <= rnd[0];
      drv <= rnd[1];
      lp <= rnd[2];
      cyc(6);
      check("serial", ser, !(sel_n | !drv));
      check("lowpwr", lpa, lp);
    end
    $display("pin test done");
    @(posedge clk);
    mr_n <= 0;
    cyc(100);
    mr_n <= 1;
    cyc(6);
    check("short", ip, 0);
    mr_n <= 0;
    cyc(600);
    check("full_rst", {usr, ip}, 3);
    mr_n <= 1;
    wait_done;
    close_out;
  end
endmodule // module_sideband_control_bench
